// >>> mcs_channel_clock.sv
`include "mcs_regs.svh"
`default_nettype none

// Function
// R1: Mode code 10 enables oscillator pin A as single-ended clock input, pin B unused.
// R2: Mode code 01 enables the on-chip crystal driver across both oscillator pins.
// R3: Doubler enable set inserts the frequency doubler after the oscillator stage.
// R4: After power-on reset registers and interface run from the ring oscillator.
// R5: Software sets master clock select once the pin oscillator is stable.
// R6: Ring oscillator disable written 1 powers the ring oscillator down.
// R7: In APLL-only operation software keeps the ring oscillator enabled.
// R8: Software programs the oscillator frequency before relying on DPLL operation.
// R9: Each of three input receivers is enabled only while its enable bit is set.
// R10: Third input pin works as general-purpose pin when not a clock input.
// R11: Software avoids doubler with external oscillator in jitter attenuation operation.
// R12: Software compensates known oscillator error via freerun offset or feedback divider.
// R13: DPLL master clock must be roughly 100, 114.285 or 125 MHz.
// R14: Selector code 11x gives DPLL+APLL operation; others give APLL-only.
// R15: Master clock source changes without runt pulses or glitches.
module mcs_channel_clock (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [1:0] osc_pin_mode_in,
    input wire logic doubler_enable_in,
    input wire logic master_clock_select_in,
    input wire logic ring_osc_disable_in,
    input wire logic [2:0] input_clock_enables_in,
    input wire logic [2:0] apll_input_select_in,
    input wire logic general_pin_three_dir_in,
    input wire logic general_pin_three_data_in,
    input wire logic third_input_pos_pin_in,
    output logic osc_pin_a_input_en_out,
    output logic crystal_driver_en_out,
    output logic doubler_active_out,
    output logic ring_osc_enable_out,
    output logic ring_clock_gate_out,
    output logic osc_clock_gate_out,
    output logic switch_busy_out,
    output logic [2:0] input_receiver_en_out,
    output logic dpll_mode_out,
    output logic third_input_pos_pin_out,
    output logic third_input_pos_pin_oe_out,
    output logic general_pin_three_value_out
);

    // Oscillator stage and analog enables
    logic osc_a_en_reg;
    logic osc_a_en_next;
    logic xtal_en_reg;
    logic xtal_en_next;
    logic doubler_reg;
    logic doubler_next;
    logic ring_en_reg;
    logic ring_en_next;
    logic [2:0] rx_en_reg;
    logic [2:0] rx_en_next;
    logic dpll_mode_reg;
    logic dpll_mode_next;

    // Pin three state
    logic pin3_out_reg;
    logic pin3_out_next;
    logic pin3_oe_reg;
    logic pin3_oe_next;
    logic pin3_val_reg;
    logic pin3_val_next;

    // Source switch state
    mcs_pkg::mcs_state_t state_reg;
    mcs_pkg::mcs_state_t state_next;
    logic [2:0] gap_cnt_reg;
    logic [2:0] gap_cnt_next;

    // Oscillator pin usage, doubler, receivers and operating mode
    always_comb begin
        osc_a_en_next = (osc_pin_mode_in == `MCS_OSC_MODE_PIN_A); // [R1]
        xtal_en_next = (osc_pin_mode_in == `MCS_OSC_MODE_XTAL); // [R2]
        // Doubler has nothing to double unless a stage feeds it
        doubler_next = doubler_enable_in && (osc_a_en_next || xtal_en_next); // [R3]
        // No interlock: disabling the ring while it is the source stops the logic it feeds
        ring_en_next = !ring_osc_disable_in; // [R6]
        rx_en_next = input_clock_enables_in; // [R9]
        dpll_mode_next = (apll_input_select_in[`MCS_APLL_SEL_MSB:`MCS_APLL_SEL_LSB] == `MCS_APLL_SEL_DPLL); // [R14]
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            osc_a_en_reg <= 1'h0;
            xtal_en_reg <= 1'h0;
            doubler_reg <= 1'h0;
            ring_en_reg <= `MCS_RST_RING_ENABLE; // [R4]
            rx_en_reg <= 3'h0;
            dpll_mode_reg <= 1'h0;
        end else begin
            osc_a_en_reg <= osc_a_en_next;
            xtal_en_reg <= xtal_en_next;
            doubler_reg <= doubler_next;
            ring_en_reg <= ring_en_next;
            rx_en_reg <= rx_en_next;
            dpll_mode_reg <= dpll_mode_next;
        end
    end

    // Third input pin: clock receiver or general-purpose pin, never both driving
    always_comb begin
        if (input_clock_enables_in[`MCS_THIRD_INPUT_BIT]) begin
            pin3_oe_next = 1'h0;
            pin3_out_next = 1'h0;
        end else begin
            pin3_oe_next = general_pin_three_dir_in; // [R10]
            pin3_out_next = general_pin_three_data_in; // [R10]
        end
        pin3_val_next = third_input_pos_pin_in;
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pin3_out_reg <= 1'h0;
            pin3_oe_reg <= 1'h0;
            pin3_val_reg <= 1'h0;
        end else begin
            pin3_out_reg <= pin3_out_next;
            pin3_oe_reg <= pin3_oe_next;
            pin3_val_reg <= pin3_val_next;
        end
    end

    // Break-before-make switch of the master clock source; both gates stay low for the gap
    // so a half-finished cycle of the old source can never merge with the new one
    always_comb begin
        state_next = state_reg;
        gap_cnt_next = gap_cnt_reg;
        case (state_reg)
            mcs_pkg::MCS_ST_RING: begin
                if (master_clock_select_in) begin // [R5]
                    state_next = mcs_pkg::MCS_ST_GAP;
                    gap_cnt_next = 3'(`MCS_SWITCH_GAP_CYCLES); // [R15]
                end
            end
            mcs_pkg::MCS_ST_GAP: begin
                if (gap_cnt_reg <= 3'h1) begin
                    // Target taken at the end, so a select that flips back mid-gap is honoured
                    state_next = master_clock_select_in ? mcs_pkg::MCS_ST_OSC : mcs_pkg::MCS_ST_RING; // [R15]
                    gap_cnt_next = `MCS_RST_COUNT;
                end else begin
                    gap_cnt_next = gap_cnt_reg - 3'h1;
                end
            end
            mcs_pkg::MCS_ST_OSC: begin
                if (!master_clock_select_in) begin
                    state_next = mcs_pkg::MCS_ST_GAP;
                    gap_cnt_next = 3'(`MCS_SWITCH_GAP_CYCLES); // [R15]
                end
            end
            default: begin
                state_next = mcs_pkg::MCS_ST_GAP;
                gap_cnt_next = 3'(`MCS_SWITCH_GAP_CYCLES);
            end
        endcase
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= mcs_pkg::MCS_ST_RING; // [R4]
            gap_cnt_reg <= `MCS_RST_COUNT;
        end else begin
            state_reg <= state_next;
            gap_cnt_reg <= gap_cnt_next;
        end
    end

    // Outputs straight from flip-flops
    assign osc_pin_a_input_en_out = osc_a_en_reg;
    assign crystal_driver_en_out = xtal_en_reg;
    assign doubler_active_out = doubler_reg;
    assign ring_osc_enable_out = ring_en_reg;
    assign ring_clock_gate_out = state_reg[0];
    assign switch_busy_out = state_reg[1];
    assign osc_clock_gate_out = state_reg[2];
    assign input_receiver_en_out = rx_en_reg;
    assign dpll_mode_out = dpll_mode_reg;
    assign third_input_pos_pin_out = pin3_out_reg;
    assign third_input_pos_pin_oe_out = pin3_oe_reg;
    assign general_pin_three_value_out = pin3_val_reg;

    // Pin A input mode
    chk_pin_a_input: assert property (@(posedge clock_in) disable iff (rst_in) // [R1]
        (osc_pin_mode_in == `MCS_OSC_MODE_PIN_A) |=> (osc_pin_a_input_en_out && !crystal_driver_en_out))
        else $error("pin A input not enabled in single-ended mode");

    // Crystal driver mode
    chk_crystal_drv_mode: assert property (@(posedge clock_in) disable iff (rst_in) // [R2]
        (osc_pin_mode_in == `MCS_OSC_MODE_XTAL) |=> (crystal_driver_en_out && !osc_pin_a_input_en_out))
        else $error("crystal driver not enabled in crystal mode");

    // Doubler follows its enable when a stage is active
    chk_doubler_follow: assert property (@(posedge clock_in) disable iff (rst_in) // [R3]
        doubler_active_out == $past(doubler_enable_in && (osc_pin_mode_in == `MCS_OSC_MODE_PIN_A
        || osc_pin_mode_in == `MCS_OSC_MODE_XTAL)))
        else $error("doubler state wrong");

    // Ring oscillator power follows the disable bit both ways
    chk_ring_power_down: assert property (@(posedge clock_in) disable iff (rst_in) // [R6]
        ##1 ring_osc_enable_out == !$past(ring_osc_disable_in))
        else $error("ring oscillator power does not follow its disable bit");

    // Gates never overlap
    chk_gates_exclusive: assert property (@(posedge clock_in) disable iff (rst_in) // [R15]
        !(ring_clock_gate_out && osc_clock_gate_out) && (ring_clock_gate_out || osc_clock_gate_out || switch_busy_out))
        else $error("clock gates overlap or none active");

    // Switch sequence: three dead cycles, then the gate picked by the select seen in the last one
    sequence s_dead_gap;
        (!ring_clock_gate_out && !osc_clock_gate_out && switch_busy_out) [*3];
    endsequence

    sequence s_target_taken;
        (osc_clock_gate_out == $past(master_clock_select_in))
        && (ring_clock_gate_out != $past(master_clock_select_in));
    endsequence

    chk_switch_to_osc: assert property (@(posedge clock_in) disable iff (rst_in) // [R5]
        (ring_clock_gate_out && master_clock_select_in) |=> s_dead_gap ##1 s_target_taken)
        else $error("switch to oscillator pin not break-before-make");

    // Ring stays the source while the select is low
    chk_ring_default: assert property (@(posedge clock_in) disable iff (rst_in) // [R4]
        (!master_clock_select_in) [*5] |-> ring_clock_gate_out)
        else $error("ring oscillator not the source while select low");

    // Receiver enables
    chk_receiver_enables: assert property (@(posedge clock_in) disable iff (rst_in) // [R9]
        ##1 input_receiver_en_out == $past(input_clock_enables_in))
        else $error("input receiver enable mismatch");

    // Pin three ownership
    chk_pin_three_gpio: assert property (@(posedge clock_in) disable iff (rst_in) // [R10]
        input_clock_enables_in[`MCS_THIRD_INPUT_BIT] |=> !third_input_pos_pin_oe_out)
        else $error("pin three driven while used as clock input");

    chk_pin_three_drive: assert property (@(posedge clock_in) disable iff (rst_in) // [R10]
        (!input_clock_enables_in[`MCS_THIRD_INPUT_BIT] && general_pin_three_dir_in)
        |=> (third_input_pos_pin_oe_out && third_input_pos_pin_out == $past(general_pin_three_data_in)))
        else $error("pin three output not driven as general pin");

    // Operating mode decode
    chk_dpll_mode: assert property (@(posedge clock_in) disable iff (rst_in) // [R14]
        ##1 dpll_mode_out == ($past(apll_input_select_in[2]) && $past(apll_input_select_in[1])))
        else $error("operating mode decode wrong");

endmodule

`default_nettype wire

// >>> mcs_regs.svh
`ifndef MCS_REGS_SVH
`define MCS_REGS_SVH

// Oscillator-pin mode codes
`define MCS_OSC_MODE_OFF 2'h0
`define MCS_OSC_MODE_XTAL 2'h1
`define MCS_OSC_MODE_PIN_A 2'h2
`define MCS_OSC_MODE_RSVD 2'h3

// APLL input selector: upper two bits 11 pick the DPLL output
`define MCS_APLL_SEL_DPLL 2'h3
`define MCS_APLL_SEL_MSB 2
`define MCS_APLL_SEL_LSB 1

// Input clock receiver bit that shares its pin with the general-purpose pin
`define MCS_THIRD_INPUT_BIT 2

// Reset values
`define MCS_RST_RING_ENABLE 1'h1
`define MCS_RST_COUNT 3'h0

// Break-before-make gap while the master clock source changes
`define MCS_CLK_PERIOD_NS 100
`define MCS_SWITCH_GAP_NS 300
`define MCS_SWITCH_GAP_CYCLES ((`MCS_SWITCH_GAP_NS + `MCS_CLK_PERIOD_NS - 1) / `MCS_CLK_PERIOD_NS)

`endif

// >>> mcs_pkg.sv
`default_nettype none

package mcs_pkg;
    // Master clock source switch, one-hot
    typedef enum logic [2:0] {
        MCS_ST_RING = 3'h1,
        MCS_ST_GAP = 3'h2,
        MCS_ST_OSC = 3'h4
    } mcs_state_t;
endpackage

`default_nettype wire

// >>> mcs_channel_clock_tb.sv
`default_nettype none

module mcs_channel_clock_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic clock_in = 1'h0;
    logic rst_in = 1'h1;
    logic [1:0] mode = 2'h0;
    logic doubler = 1'h0, sel = 1'h0, rdis = 1'h0, dir = 1'h0, dat = 1'h0, pin = 1'h0;
    logic [2:0] rx_on = 3'h0, asel = 3'h0, v;
    wire logic osc_a, xtal, dblo, ring_en, rg, og, busy, dpll, p3_out, p3_oe, p3_val;
    wire logic [2:0] rx;
    int err_count = 0;
    int total_checks = 0;

    mcs_channel_clock dut_u (
        .clock_in(clock_in), .rst_in(rst_in), .osc_pin_mode_in(mode), .doubler_enable_in(doubler),
        .master_clock_select_in(sel), .ring_osc_disable_in(rdis), .input_clock_enables_in(rx_on),
        .apll_input_select_in(asel), .general_pin_three_dir_in(dir), .general_pin_three_data_in(dat),
        .third_input_pos_pin_in(pin), .osc_pin_a_input_en_out(osc_a), .crystal_driver_en_out(xtal),
        .doubler_active_out(dblo), .ring_osc_enable_out(ring_en), .ring_clock_gate_out(rg),
        .osc_clock_gate_out(og), .switch_busy_out(busy), .input_receiver_en_out(rx),
        .dpll_mode_out(dpll), .third_input_pos_pin_out(p3_out), .third_input_pos_pin_oe_out(p3_oe),
        .general_pin_three_value_out(p3_val)
    );

    // 10 MHz clock
    initial begin
        forever #50 clock_in = ~clock_in;
    end

    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Registered outputs settle on the edge after the one that drives the input
    task automatic settle;
        repeat (2) @(negedge clock_in);
    endtask

    // Three gap cycles with both gates low, then only the target gate
    task automatic gap_check(input logic tgt);
        for (int c = 0; c < 3; c++) begin
            @(negedge clock_in);
            chk({1'h0, busy, rg, og}, 4'h4);
        end
        @(negedge clock_in);
        chk({1'h0, busy, rg, og}, {2'h0, ~tgt, tgt});
    endtask

    task automatic complete_run;
        if (err_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Whole sequence needs well under 200 cycles
    initial begin
        #(100 * 2000);
        err_count++;
        complete_run();
    end

    initial begin
        repeat (5) @(posedge clock_in);
        @(negedge clock_in);
        chk({ring_en, rg, og, busy}, 4'hc);
        chk({osc_a, xtal, dblo, dpll}, 4'h0);
        @(posedge clock_in);
        rst_in <= 1'h0;
        // Every mode code with the doubler requested; APLL-only, where either source may use it
        for (int m = 0; m < 4; m++) begin
            @(posedge clock_in);
            mode <= 2'(m);
            doubler <= 1'h1;
            settle();
            chk({1'h0, osc_a, xtal, dblo}, {1'h0, m == 2, m == 1, m == 1 || m == 2});
        end
        @(posedge clock_in);
        mode <= 2'h1;
        doubler <= 1'h0;
        settle();
        chk({1'h0, osc_a, xtal, dblo}, 4'h2);
        // Receivers, pin three sharing and selector codes; ring left up while APLL-only
        for (int i = 0; i < 8; i++) begin
            v = 3'(i);
            @(posedge clock_in);
            rx_on <= v;
            dir <= 1'h1;
            dat <= v[0];
            pin <= v[1];
            asel <= v;
            settle();
            chk({1'h0, rx}, {1'h0, v});
            chk({1'h0, p3_oe, p3_out, p3_val}, {1'h0, ~v[2], ~v[2] & v[0], v[1]});
            chk({3'h0, dpll}, {3'h0, v[2:1] == 2'h3});
        end
        // Enable dropped: the data bit still follows, but nothing drives the pin
        @(posedge clock_in);
        rx_on <= 3'h0;
        dir <= 1'h0;
        dat <= 1'h1;
        settle();
        chk({2'h0, p3_oe, p3_out}, 4'h1);
        // Ring to pin oscillator in DPLL+APLL mode; the pin clock counts as stable, in range and
        // frequency-programmed, since setup and error trimming live outside this block
        @(posedge clock_in);
        sel <= 1'h1;
        @(negedge clock_in);
        gap_check(1'h1);
        repeat (3) @(negedge clock_in);
        chk({1'h0, busy, rg, og}, 4'h1);
        // Ring power follows the disable bit, only once the ring no longer feeds the logic
        for (int r = 1; r >= 0; r--) begin
            @(posedge clock_in);
            rdis <= r[0];
            settle();
            chk({3'h0, ring_en}, {3'h0, ~r[0]});
        end
        // Reversal right after the gap opens still costs the full gap
        @(posedge clock_in);
        sel <= 1'h0;
        @(posedge clock_in);
        sel <= 1'h1;
        gap_check(1'h1);
        // Back to the ring oscillator
        @(posedge clock_in);
        sel <= 1'h0;
        @(negedge clock_in);
        gap_check(1'h0);
        complete_run();
    end
endmodule

`default_nettype wire
